// >>> core/ehp_pkg.sv
package ehp_pkg;
  // host address select: one bit picks the location within a decode range
  localparam logic LOC_DATA = 1'b0;
  localparam logic LOC_STATUS_COMMAND = 1'b1;
  // status byte field positions
  localparam int ST_OUTPUT_BUFFER_FULL = 0;
  localparam int ST_INPUT_BUFFER_FULL = 1;
  localparam int ST_IGNORED_LO = 2;
  localparam int ST_COMMAND_BYTE = 3;
  localparam int ST_BURST = 4;
  localparam int ST_OS_EVENT_PENDING = 5;
  localparam int ST_MGMT_EVENT_PENDING = 6;
  localparam int ST_IGNORED_HI = 7;
  // reset value, and the number of decode ranges
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [1:0] RANGES = 2'h2;
  // range indices of the shared interface and of the private os-only interface
  localparam logic RANGE_SHARED = 1'b0;
  localparam logic RANGE_PRIVATE = 1'b1;
  // owner of a pending output request on the shared range
  typedef enum logic [1:0] {
    EHP_REQ_NONE = 2'b00,
    EHP_REQ_OS = 2'b01,
    EHP_REQ_MGMT = 2'b10
  } ehp_req_e;
endpackage

// >>> core/ehp_channel.sv
// one decode range: status/command plus data, with the buffer handshake
module ehp_channel
  import ehp_pkg::*;
(
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // host side, already synchronised
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic host_loc,
  input wire logic [7:0] host_wdata,
  // controller side
  input wire logic ctl_put,
  input wire logic [7:0] ctl_put_byte,
  input wire logic ctl_take,
  input wire logic ctl_os_event,
  input wire logic ctl_os_event_clr,
  input wire logic ctl_mgmt_event,
  input wire logic ctl_mgmt_event_clr,
  input wire logic burst_set,
  input wire logic burst_clr,
  // observed state
  output logic [7:0] status,
  output logic [7:0] in_byte,
  output logic [7:0] out_byte,
  output logic put_ok
);
  typedef struct packed {
    logic [7:0] in_data;   // input data register
    logic [7:0] out_data;  // output data register
    logic output_buffer_full;
    logic input_buffer_full;
    logic cmd;
    logic burst;
    logic os_evt;
    logic mgmt_evt;
  } ehp_ch_s;
  ehp_ch_s st_q, st_d;

  // next state: host events and controller events, sets win over clears
  always_comb begin
    st_d = st_q;
    // controller consumes the received byte
    if (ctl_take && st_q.input_buffer_full) begin
      st_d.input_buffer_full = 1'b0;
    end
    // host reads data location: byte collected
    if (host_rd && host_loc == LOC_DATA) begin
      st_d.output_buffer_full = 1'b0;
    end
    // controller places a byte only into an empty output buffer
    if (ctl_put && !st_q.output_buffer_full) begin
      st_d.out_data = ctl_put_byte;
      st_d.output_buffer_full = 1'b1;
    end
    // host writes land in the one input data register
    if (host_wr) begin
      st_d.in_data = host_wdata;
      st_d.input_buffer_full = 1'b1;
      if (host_loc == LOC_STATUS_COMMAND) begin
        st_d.cmd = 1'b1;
      end else begin
        st_d.cmd = 1'b0;
      end
    end
    // event flags; a new event beats a same-cycle clear
    if (ctl_os_event_clr) st_d.os_evt = 1'b0;
    if (ctl_os_event) st_d.os_evt = 1'b1;
    if (ctl_mgmt_event_clr) st_d.mgmt_evt = 1'b0;
    if (ctl_mgmt_event) st_d.mgmt_evt = 1'b1;
    // burst only on accepted burst-enable, seen by controller
    if (burst_clr) st_d.burst = 1'b0;
    if (burst_set) st_d.burst = 1'b1;
  end

  // state register, frozen while clock enable is low
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  // status byte; ignored bits read as zero
  always_comb begin
    status = 8'h00;
    status[ST_OUTPUT_BUFFER_FULL] = st_q.output_buffer_full;
    status[ST_INPUT_BUFFER_FULL] = st_q.input_buffer_full;
    status[ST_COMMAND_BYTE] = st_q.cmd;
    status[ST_BURST] = st_q.burst;
    status[ST_OS_EVENT_PENDING] = st_q.os_evt;
    status[ST_MGMT_EVENT_PENDING] = st_q.mgmt_evt;
  end
  assign in_byte = st_q.in_data;
  assign out_byte = st_q.out_data;
  assign put_ok = !st_q.output_buffer_full;
endmodule

// >>> core/ehp_host_port.sv
// Behaviour
// - two locations, three registers per range
// - status read, command write, one location
// - data location carries bytes both ways
// - output-full set on controller byte
// - host data read clears output-full
// - input-full set on any host write
// - controller read clears input-full
// - controller takes byte only when input-full
// - controller puts byte only when output-empty
// - os event bit set, then os interrupt
// - mgmt event bit set, then mgmt request
// - burst bit shows burst mode
// - burst only after accepted burst-enable
// - shared output only after a request
// - second private range has no mgmt events and no request gate
// - command write latches, sets input-full, command
// - data write latches, sets input-full
module ehp_host_port
  import ehp_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  // host pins: strobes are one-cycle pulses after synchronising
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_range,
  input wire logic host_loc,
  input wire logic [7:0] host_din,
  output logic [7:0] host_dout,
  output logic host_dout_oe,
  // controller side, same clock
  input wire logic ctl_range,
  input wire logic ctl_put,
  input wire logic [7:0] ctl_put_byte,
  input wire logic ctl_take,
  input wire logic ctl_os_event,
  input wire logic ctl_os_event_clr,
  input wire logic ctl_mgmt_event,
  input wire logic ctl_mgmt_event_clr,
  input wire logic ctl_burst_enter,
  input wire logic ctl_burst_exit,
  input wire logic ctl_grant_os,
  input wire logic ctl_grant_mgmt,
  // controller observations
  output logic [7:0] ctl_status,
  output logic [7:0] ctl_in_byte,
  output logic ctl_put_ok,
  // host interrupt requests
  output logic os_irq,
  output logic mgmt_irq
);
  // all registered state of the top
  typedef struct packed {
    logic [1:0] cs_n_s1;
    logic [1:0] cs_n_s2;
    logic [1:0] rd_n_s1;
    logic [1:0] rd_n_s2;
    logic [1:0] wr_n_s1;
    logic [1:0] wr_n_s2;
    logic [1:0] addr_s1;  // range, location
    logic [1:0] addr_s2;
    logic [7:0] din_s1;
    logic [7:0] din_s2;
    logic rd_prev;        // for edge detect of read
    logic wr_prev;
    logic [7:0] dout;
    logic dout_oe;
    logic [7:0] ctl_status;
    logic [7:0] ctl_in_byte;
    logic ctl_put_ok;
    logic os_irq;
    logic mgmt_irq;
    ehp_req_e req_owner;  // who asked for output on the shared range
  } ehp_top_s;
  ehp_top_s q, d;

  // per-range wires
  logic [1:0] ch_wr, ch_rd, ch_put, ch_take, ch_ose, ch_osc, ch_me, ch_mc;
  logic [1:0] ch_bs, ch_bc, ch_put_ok;
  logic [7:0] ch_status [2];
  logic [7:0] ch_in [2];
  logic [7:0] ch_out [2];
  logic rd_now, wr_now, rd_pulse, wr_pulse, sel_range, sel_loc;
  logic shared_put_allowed;

  // synchronised strobe levels, qualified by chip select
  assign rd_now = !q.cs_n_s2[1] && !q.rd_n_s2[1];
  assign wr_now = !q.cs_n_s2[1] && !q.wr_n_s2[1];
  assign rd_pulse = rd_now && !q.rd_prev;
  assign wr_pulse = wr_now && !q.wr_prev;
  assign sel_range = q.addr_s2[1];
  assign sel_loc = q.addr_s2[0];
  // output on shared range waits for an explicit request from a host party
  assign shared_put_allowed = q.req_owner != EHP_REQ_NONE;

  // steering of host and controller strobes to a decode range
  always_comb begin
    for (int i = 0; i < RANGES; i++) begin
      ch_wr[i] = wr_pulse && (sel_range == 1'(i));
      ch_rd[i] = rd_pulse && (sel_range == 1'(i));
      ch_take[i] = ctl_take && (ctl_range == 1'(i));
      ch_ose[i] = ctl_os_event && (ctl_range == 1'(i));
      ch_osc[i] = ctl_os_event_clr && (ctl_range == 1'(i));
      ch_me[i] = ctl_mgmt_event && (ctl_range == 1'(i));
      ch_mc[i] = ctl_mgmt_event_clr && (ctl_range == 1'(i));
      ch_bs[i] = ctl_burst_enter && (ctl_range == 1'(i));
      ch_bc[i] = ctl_burst_exit && (ctl_range == 1'(i));
      ch_put[i] = ctl_put && (ctl_range == 1'(i));
    end
    // the shared range is gated by the request owner
    ch_put[RANGE_SHARED] = ctl_put && (ctl_range == RANGE_SHARED) && shared_put_allowed;
  end

  // the two decode ranges; the private one is os-only, no mgmt events
  for (genvar g = 0; g < 2; g++) begin : g_rng
    ehp_channel u_ch (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .host_wr(ch_wr[g]),
      .host_rd(ch_rd[g]),
      .host_loc(sel_loc),
      .host_wdata(q.din_s2),
      .ctl_put(ch_put[g]),
      .ctl_put_byte(ctl_put_byte),
      .ctl_take(ch_take[g]),
      .ctl_os_event(ch_ose[g]),
      .ctl_os_event_clr(ch_osc[g]),
      .ctl_mgmt_event(g == 0 ? ch_me[g] : 1'b0),
      .ctl_mgmt_event_clr(ch_mc[g]),
      .burst_set(ch_bs[g]),
      .burst_clr(ch_bc[g]),
      .status(ch_status[g]),
      .in_byte(ch_in[g]),
      .out_byte(ch_out[g]),
      .put_ok(ch_put_ok[g])
    );
  end

  // next state of the top
  always_comb begin
    d = q;
    // four-flop chains on the strobe pins, two flops on address and data pins
    d.cs_n_s1 = {q.cs_n_s1[0], host_cs_n};
    d.cs_n_s2 = {q.cs_n_s2[0], q.cs_n_s1[1]};
    d.rd_n_s1 = {q.rd_n_s1[0], host_rd_n};
    d.rd_n_s2 = {q.rd_n_s2[0], q.rd_n_s1[1]};
    d.wr_n_s1 = {q.wr_n_s1[0], host_wr_n};
    d.wr_n_s2 = {q.wr_n_s2[0], q.wr_n_s1[1]};
    d.addr_s1 = {host_range, host_loc};
    d.addr_s2 = q.addr_s1;
    d.din_s1 = host_din;
    d.din_s2 = q.din_s1;
    d.rd_prev = rd_now;
    d.wr_prev = wr_now;
    // read data: status location gives status, data location the output byte
    if (rd_now) begin
      d.dout = (sel_loc == LOC_STATUS_COMMAND) ? ch_status[sel_range]
                                              : ch_out[sel_range];
      d.dout_oe = 1'b1;
    end else begin
      d.dout_oe = 1'b0;
    end
    // controller view of the selected range
    d.ctl_status = ch_status[ctl_range];
    d.ctl_in_byte = ch_in[ctl_range];
    d.ctl_put_ok = ch_put_ok[ctl_range] &&
                   (ctl_range == RANGE_PRIVATE || shared_put_allowed);
    // request owner: granted by controller firmware, retired when a byte is put
    if (ch_put[RANGE_SHARED] && ch_put_ok[RANGE_SHARED]) d.req_owner = EHP_REQ_NONE;
    if (ctl_grant_mgmt) d.req_owner = EHP_REQ_MGMT;
    if (ctl_grant_os) d.req_owner = EHP_REQ_OS;
    // interrupts follow the pending bits, one cycle behind them
    d.os_irq = ch_status[0][ST_OS_EVENT_PENDING] ||
               ch_status[1][ST_OS_EVENT_PENDING];
    d.mgmt_irq = ch_status[0][ST_MGMT_EVENT_PENDING];
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.cs_n_s1 <= 2'h3;
      q.cs_n_s2 <= 2'h3;
      q.rd_n_s1 <= 2'h3;
      q.rd_n_s2 <= 2'h3;
      q.wr_n_s1 <= 2'h3;
      q.wr_n_s2 <= 2'h3;
      q.ctl_put_ok <= 1'b0;
      q.req_owner <= EHP_REQ_NONE;
    end else if (clk_en) begin
      q <= d;
    end
  end

  // outputs straight from flops
  assign host_dout = q.dout;
  assign host_dout_oe = q.dout_oe;
  assign ctl_status = q.ctl_status;
  assign ctl_in_byte = q.ctl_in_byte;
  assign ctl_put_ok = q.ctl_put_ok;
  assign os_irq = q.os_irq;
  assign mgmt_irq = q.mgmt_irq;
endmodule

// >>> tb/ehp_host_port_sva.sv
module ehp_host_port_sva (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // host pins
  input wire logic host_cs_n,
  input wire logic host_rd_n,
  input wire logic host_wr_n,
  input wire logic host_range,
  input wire logic host_loc,
  input wire logic host_dout_oe,
  // controller side
  input wire logic ctl_range,
  input wire logic ctl_take,
  input wire logic ctl_os_event,
  input wire logic ctl_mgmt_event,
  input wire logic ctl_burst_enter,
  input wire logic ctl_burst_exit,
  input wire logic [7:0] ctl_status,
  input wire logic os_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // host write into the range the controller watches
  sequence s_wr;
    $fell(host_wr_n) && !host_cs_n && host_range == ctl_range;
  endsequence
  property p_ign; ctl_status[7] == 1'b0 && ctl_status[2] == 1'b0; endproperty
  a_ign: assert property (p_ign) else $error("ignored bits set");
  property p_cmd; s_wr ##0 host_loc |-> ##[3:6] ctl_status[1] && ctl_status[3]; endproperty
  a_cmd: assert property (p_cmd) else $error("command write flags");
  property p_dat; s_wr ##0 !host_loc |-> ##[3:6] ctl_status[1] && !ctl_status[3]; endproperty
  a_dat: assert property (p_dat) else $error("data write flags");
  property p_take; ctl_take |-> ##[1:3] !ctl_status[1]; endproperty
  a_take: assert property (p_take) else $error("take kept input full");
  property p_os; ctl_os_event |-> ##[1:3] ctl_status[5] && os_irq; endproperty
  a_os: assert property (p_os) else $error("os event missing");
  property p_mg; ctl_mgmt_event && !ctl_range |-> ##[1:3] ctl_status[6]; endproperty
  a_mg: assert property (p_mg) else $error("mgmt event missing");
  property p_bon; ctl_burst_enter |-> ##[1:3] ctl_status[4]; endproperty
  a_bon: assert property (p_bon) else $error("burst not shown");
  property p_boff; ctl_burst_exit |-> ##[1:3] !ctl_status[4]; endproperty
  a_boff: assert property (p_boff) else $error("burst not cleared");
  property p_oe; host_rd_n [*6] |-> !host_dout_oe; endproperty
  a_oe: assert property (p_oe) else $error("drive without read");
  c_oe: cover property ($rose(host_dout_oe));
  c_os: cover property (os_irq);
  c_burst: cover property (ctl_status[4]);
endmodule

// >>> tb/ehp_host_model.sv
// host processor side: strobed byte reads and writes
module ehp_host_model (
  // clock and range choice
  input wire logic ref_clk,
  input wire logic rg,
  // host pins
  output logic cs_n,
  output logic rd_n,
  output logic wr_n,
  output logic range,
  output logic loc,
  output logic [7:0] din,
  input wire logic [7:0] dout
);
  timeunit 1ns;
  timeprecision 1ps;
  assign range = rg;
  initial begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    loc = 1'b1;
    din = 8'h00;
  end
  // read held until data has settled, then gap before next strobe
  // all host traffic comes from one caller, so shared use is serialised
  task automatic rd(input logic l, output logic [7:0] v);
    @(negedge ref_clk);
    loc = l;
    cs_n = 1'b0;
    rd_n = 1'b0;
    // byte is launched on the fifth edge; take it one edge later, settled
    repeat (6) @(posedge ref_clk);
    v = dout;
    @(negedge ref_clk);
    cs_n = 1'b1;
    rd_n = 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
  // status first, data only after it
  task automatic rd_data(output logic [7:0] s, output logic [7:0] v);
    rd(1'b1, s);
    rd(1'b0, v);
  endtask
  // poll input-full clear before each write
  task automatic wr(input logic l, input logic [7:0] b);
    logic [7:0] s;
    s = 8'h02;
    while (s[1]) rd(1'b1, s);
    @(negedge ref_clk);
    loc = l;
    din = b;
    cs_n = 1'b0;
    wr_n = 1'b0;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    cs_n = 1'b1;
    wr_n = 1'b1;
    din = ~b; // released bus shows no stale byte
    repeat (5) @(posedge ref_clk);
  endtask
endmodule

// >>> tb/ehp_host_port_tb.sv
module ehp_host_port_tb;
  import ehp_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic rg = 1'b0;
  logic [9:0] p = 10'h0; // controller pulses
  logic [7:0] cpb = 8'h00;
  logic cs_n, rd_n, wr_n, hr, hl, oe, oi, mi, pok;
  logic [7:0] hd, dout, st, inb, b, d, s, v;
  int seed = 6;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  always #2.5 ref_clk = ~ref_clk;
  ehp_host_model i_ehp_host_model (.ref_clk(ref_clk), .rg(rg), .cs_n(cs_n), .rd_n(rd_n),
    .wr_n(wr_n), .range(hr), .loc(hl), .din(hd), .dout(dout));
  ehp_host_port i_ehp_host_port (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1),
    .host_cs_n(cs_n), .host_rd_n(rd_n), .host_wr_n(wr_n), .host_range(hr), .host_loc(hl),
    .host_din(hd), .host_dout(dout), .host_dout_oe(oe), .ctl_range(rg), .ctl_put(p[0]),
    .ctl_put_byte(cpb), .ctl_take(p[1]), .ctl_os_event(p[2]), .ctl_os_event_clr(p[3]),
    .ctl_mgmt_event(p[4]), .ctl_mgmt_event_clr(p[5]), .ctl_burst_enter(p[6]),
    .ctl_burst_exit(p[7]), .ctl_grant_os(p[8]), .ctl_grant_mgmt(p[9]), .ctl_status(st),
    .ctl_in_byte(inb), .ctl_put_ok(pok), .os_irq(oi), .mgmt_irq(mi));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  // one-cycle controller pulse, then let status settle
  task automatic pl(int i);
    @(negedge ref_clk);
    p[i] = 1'b1;
    @(negedge ref_clk);
    p = 10'h0;
    repeat (3) @(negedge ref_clk);
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    sys_rst = 1'b0;
    chk("oe", 8'h00, {7'h0, oe});
    for (int r = 0; r < 2; r++) begin
      rg = r[0];
      b = 8'($random(seed));
      i_ehp_host_model.wr(1'b1, b);
      chk("in", b, inb);
      chk("ibf_cmd", 8'h0a, st & 8'h0a);
      pl(1);
      chk("ibf", 8'h00, st & 8'h02);
      b = 8'($random(seed));
      i_ehp_host_model.wr(1'b0, b);
      chk("in", b, inb);
      chk("ibf_dat", 8'h02, st & 8'h0a);
      pl(1);
      // shared range offers no room until a host party has asked
      chk("put_ok", {7'h0, r[0]}, {7'h0, pok});
      cpb = 8'($random(seed));
      d = cpb;
      pl(0);
      chk("obf", {7'h0, r[0]}, st & 8'h01);
      if (r == 0) begin
        pl(8);
        chk("put_ok", 8'h01, {7'h0, pok});
        pl(0);
      end
      chk("obf", 8'h01, st & 8'h01);
      chk("put_ok", 8'h00, {7'h0, pok});
      cpb = ~d;
      pl(0);
      i_ehp_host_model.rd_data(s, v);
      chk("st", 8'h01, s & 8'h85);
      chk("out", d, v);
      i_ehp_host_model.rd(1'b1, s);
      chk("obf", 8'h00, s & 8'h01);
      // grant on the shared range is used up by the accepted byte
      chk("put_ok", {7'h0, r[0]}, {7'h0, pok});
      pl(2);
      chk("os", 8'h21, {st[7:4], 3'h0, oi} & 8'h21);
      pl(3);
      chk("os", 8'h00, {st[7:4], 3'h0, oi} & 8'h21);
      if (r == 0) begin
        pl(4);
        chk("mg", 8'h41, {st[7:4], 3'h0, mi} & 8'h41);
        pl(5);
      end
      pl(6);
      chk("burst", 8'h10, st & 8'h10);
      pl(7);
      chk("burst", 8'h00, st & 8'h10);
    end
    finish_test();
  end
endmodule
bind ehp_host_port ehp_host_port_sva i_ehp_host_port_sva (.ref_clk(ref_clk),
  .sys_rst(sys_rst), .host_cs_n(host_cs_n), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
  .host_range(host_range), .host_loc(host_loc), .host_dout_oe(host_dout_oe),
  .ctl_range(ctl_range), .ctl_take(ctl_take), .ctl_os_event(ctl_os_event),
  .ctl_mgmt_event(ctl_mgmt_event), .ctl_burst_enter(ctl_burst_enter),
  .ctl_burst_exit(ctl_burst_exit), .ctl_status(ctl_status), .os_irq(os_irq));
